// File: i2c_port_pkg.sv
`default_nettype none
package i2c_port_pkg;
    localparam logic [4:0]  ADDR_FIXED_BITS   = 5'h0A;
    localparam int          ADDR_FIXED_POS    = 2;
    localparam logic [0:0]  DIR_WRITE         = 1'h1 - 1'h1;
    localparam logic [0:0]  DIR_READ          = 1'h1;
    localparam logic [7:0]  FIFO_REG_ADDR     = 8'h05;
    localparam logic [7:0]  REG_PTR_RESET     = 8'h00;
    localparam int          CLOCK_HZ          = 10_000_000;
    localparam int          SPIKE_WIDTH_NS    = 50;
    localparam int          SPIKE_CYCLES      = ((SPIKE_WIDTH_NS * (CLOCK_HZ / 1_000_000))
                                                 + 999) / 1000;
    localparam int          FIFO_WIDTH        = 8;
    localparam int          FIFO_DEPTH        = 8;

    function automatic logic [6:0] own_address(input logic [1:0] low_bits);
        own_address = {ADDR_FIXED_BITS, low_bits};
    endfunction : own_address
endpackage : i2c_port_pkg
`default_nettype wire

// File: i2c_pin_filter.sv
`default_nettype none
module i2c_pin_filter
    import i2c_port_pkg::*;
#(
    parameter int STABLE_CYCLES = 1
)(
    input  wire logic i_clock,
    input  wire logic i_rst,
    input  wire logic i_pin,
    output logic      o_level
);
    // Three stage synchroniser, then a change counts once stages two and three agree.
    logic [2:0] sync_q;
    logic [2:0] sync_d;
    logic       level_q;
    logic       level_d;
    logic [3:0] count_q;
    logic [3:0] count_d;

    always_comb
    begin
        sync_d  = {sync_q[1:0], i_pin};
        level_d = level_q;
        count_d = 4'h0;
        if ((sync_q[1] == sync_q[2]) && (sync_q[2] != level_q))
        begin
            count_d = count_q + 4'h1;
            if (count_q >= 4'(STABLE_CYCLES - 1))
            begin
                level_d = sync_q[2];
                count_d = 4'h0;
            end
        end
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            sync_q  <= 3'h7;
            level_q <= 1'h1;
            count_q <= 4'h0;
        end
        else
        begin
            sync_q  <= sync_d;
            level_q <= level_d;
            count_q <= count_d;
        end
    end

    assign o_level = level_q;
endmodule : i2c_pin_filter
`default_nettype wire

// File: i2c_byte_fifo.sv
`default_nettype none
module i2c_byte_fifo
    import i2c_port_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
)(
    input  wire logic             i_clock,
    input  wire logic             i_rst,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      wr_d;
    logic [AW:0]      rd_q;
    logic [AW:0]      rd_d;
    logic             push;
    logic             pop;

    assign o_in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign o_out_valid = wr_q != rd_q;
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;
    assign o_out_data  = mem_q[rd_q[AW-1:0]];

    always_comb
    begin
        wr_d = push ? wr_q + (AW+1)'(1) : wr_q;
        rd_d = pop ? rd_q + (AW+1)'(1) : rd_q;
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            wr_q <= '0;
            rd_q <= '0;
        end
        else
        begin
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (push)
        begin
            mem_q[wr_q[AW-1:0]] <= i_in_data;
        end
    end
endmodule : i2c_byte_fifo
`default_nettype wire

// File: i2c_slave_register_port.sv
`default_nettype none
module i2c_slave_register_port
    import i2c_port_pkg::*;
#(
    parameter int FIFO_W = FIFO_WIDTH,
    parameter int FIFO_D = FIFO_DEPTH
)(
    input  wire logic       i_clock,
    input  wire logic       i_rst,
    input  wire logic       i_port_select,
    input  wire logic       i_push_pull_short_link,
    input  wire logic       i_addr_from_setting,
    input  wire logic [1:0] i_addr_setting,
    input  wire logic [1:0] i_addr_pins,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    output logic            o_sda,
    output logic            o_sda_oe_n,
    output logic            o_reg_wr,
    output logic            o_reg_rd,
    output logic [7:0]      o_reg_addr,
    output logic [7:0]      o_reg_wdata,
    input  wire logic [7:0] i_reg_rdata,
    output logic            o_fifo_valid,
    input  wire logic       i_fifo_ready,
    output logic [7:0]      o_fifo_data,
    input  wire logic       i_rfifo_valid,
    output logic            o_rfifo_pop,
    input  wire logic [7:0] i_rfifo_data,
    output logic            o_busy
);
    typedef enum logic [5:0] {
        ST_IDLE  = 6'b000001,
        ST_ADDR  = 6'b000010,
        ST_RECV  = 6'b000100,
        ST_RACK  = 6'b001000,
        ST_SEND  = 6'b010000,
        ST_TACK  = 6'b100000
    } state_t;

    logic scl_f;
    logic sda_f;
    logic scl_q;
    logic sda_q;

    // Filtered line levels; the filter spans spikes when the port is selected.
    i2c_pin_filter #(.STABLE_CYCLES(SPIKE_CYCLES)) u_scl_filter (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_pin   (i_scl | ~i_port_select),
        .o_level (scl_f)
    );
    i2c_pin_filter #(.STABLE_CYCLES(SPIKE_CYCLES)) u_sda_filter (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_pin   (i_sda | ~i_port_select),
        .o_level (sda_f)
    );

    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    assign scl_rise   = scl_f && !scl_q;
    assign scl_fall   = !scl_f && scl_q;
    assign start_seen = scl_f && scl_q && sda_q && !sda_f;
    assign stop_seen  = scl_f && scl_q && !sda_q && sda_f;

    state_t     state_q, state_d;
    logic [7:0] shift_q, shift_d;
    logic [3:0] bit_q, bit_d;
    logic [7:0] ptr_q, ptr_d;
    logic       have_ptr_q, have_ptr_d;
    logic       drive_q, drive_d;
    logic       out_q, out_d;
    logic       busy_q, busy_d;
    logic       nack_q, nack_d;
    logic       wr_q, wr_d;
    logic       rd_q, rd_d;
    logic       pop_q, pop_d;
    logic [7:0] wdata_q, wdata_d;
    logic [7:0] waddr_q, waddr_d;
    logic       to_fifo_q, to_fifo_d;
    logic [1:0] low_bits;
    logic       fifo_in_ready;
    logic [7:0] tx_byte;

    // The short link takes its upper select bit as zero when strapped by pin.
    assign low_bits = i_addr_from_setting ? i_addr_setting
                    : (i_push_pull_short_link ? {1'h0, i_addr_pins[0]} : i_addr_pins);
    assign tx_byte  = (ptr_q == FIFO_REG_ADDR) ? i_rfifo_data : i_reg_rdata;

    always_comb
    begin
        state_d    = state_q;
        shift_d    = shift_q;
        bit_d      = bit_q;
        ptr_d      = ptr_q;
        have_ptr_d = have_ptr_q;
        drive_d    = drive_q;
        out_d      = out_q;
        busy_d     = busy_q;
        nack_d     = nack_q;
        wr_d       = 1'h0;
        rd_d       = 1'h0;
        pop_d      = 1'h0;
        wdata_d    = wdata_q;
        waddr_d    = waddr_q;
        to_fifo_d  = to_fifo_q && !fifo_in_ready;
        if (!i_port_select || stop_seen)
        begin
            state_d = ST_IDLE;
            busy_d  = 1'h0;
            drive_d = 1'h0;
        end
        else if (start_seen)
        begin
            state_d = ST_ADDR;
            busy_d  = 1'h1;
            bit_d   = 4'h0;
            drive_d = 1'h0;
        end
        else
        begin
            case (state_q)
                ST_ADDR, ST_RECV:
                begin
                    if (scl_rise)
                    begin
                        shift_d = {shift_q[6:0], sda_f};
                        bit_d   = bit_q + 4'h1;
                    end
                    else if (scl_fall && bit_q == 4'h8)
                    begin
                        bit_d = 4'h0;
                        if (state_q == ST_ADDR)
                        begin
                            // General call (address zero) never matches here.
                            if (shift_q[7:1] == own_address(low_bits))
                            begin
                                drive_d = 1'h1;
                                out_d   = 1'h0;
                                state_d = ST_RACK;
                                nack_d  = shift_q[0] == DIR_READ;
                                have_ptr_d = 1'h0;
                            end
                            else
                            begin
                                state_d = ST_IDLE;
                            end
                        end
                        else
                        begin
                            state_d = ST_RACK;
                            drive_d = 1'h1;
                            out_d   = 1'h0;
                            if (!have_ptr_q)
                            begin
                                ptr_d      = shift_q;
                                have_ptr_d = 1'h1;
                            end
                            else if (ptr_q == FIFO_REG_ADDR)
                            begin
                                wdata_d   = shift_q;
                                to_fifo_d = 1'h1;
                            end
                            else
                            begin
                                wdata_d = shift_q;
                                waddr_d = ptr_q;
                                wr_d    = 1'h1;
                                ptr_d   = ptr_q + 8'h01;
                            end
                        end
                    end
                end
                ST_RACK:
                begin
                    if (scl_fall)
                    begin
                        if (nack_q)
                        begin
                            // Read frame: load first byte and drive its MSB.
                            state_d = ST_SEND;
                            shift_d = tx_byte;
                            waddr_d = ptr_q;
                            rd_d    = 1'h1;
                            pop_d   = ptr_q == FIFO_REG_ADDR;
                            ptr_d   = (ptr_q == FIFO_REG_ADDR) ? ptr_q : ptr_q + 8'h01;
                            out_d   = tx_byte[7];
                            drive_d = 1'h1;
                            bit_d   = 4'h0;
                            nack_d  = 1'h0;
                        end
                        else
                        begin
                            state_d = ST_RECV;
                            drive_d = 1'h0;
                        end
                    end
                end
                ST_SEND:
                begin
                    if (scl_rise)
                    begin
                        bit_d = bit_q + 4'h1;
                    end
                    else if (scl_fall)
                    begin
                        if (bit_q == 4'h8)
                        begin
                            state_d = ST_TACK;
                            drive_d = 1'h0;
                        end
                        else
                        begin
                            shift_d = {shift_q[6:0], 1'h0};
                            out_d   = shift_q[6];
                        end
                    end
                end
                ST_TACK:
                begin
                    if (scl_rise)
                    begin
                        nack_d = sda_f;
                    end
                    else if (scl_fall)
                    begin
                        if (nack_q)
                        begin
                            state_d = ST_IDLE;
                            drive_d = 1'h0;
                        end
                        else
                        begin
                            state_d = ST_SEND;
                            shift_d = tx_byte;
                            waddr_d = ptr_q;
                            rd_d    = 1'h1;
                            pop_d   = ptr_q == FIFO_REG_ADDR;
                            ptr_d   = (ptr_q == FIFO_REG_ADDR) ? ptr_q : ptr_q + 8'h01;
                            out_d   = tx_byte[7];
                            drive_d = 1'h1;
                            bit_d   = 4'h0;
                        end
                    end
                end
                ST_IDLE:
                begin
                    drive_d = 1'h0;
                end
                default:
                begin
                    state_d = ST_IDLE;
                    drive_d = 1'h0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_q    <= ST_IDLE;
            shift_q    <= 8'h00;
            bit_q      <= 4'h0;
            ptr_q      <= REG_PTR_RESET;
            have_ptr_q <= 1'h0;
            drive_q    <= 1'h0;
            out_q      <= 1'h1;
            busy_q     <= 1'h0;
            nack_q     <= 1'h0;
            wr_q       <= 1'h0;
            rd_q       <= 1'h0;
            pop_q      <= 1'h0;
            wdata_q    <= 8'h00;
            waddr_q    <= 8'h00;
            to_fifo_q  <= 1'h0;
            scl_q      <= 1'h1;
            sda_q      <= 1'h1;
        end
        else
        begin
            state_q    <= state_d;
            shift_q    <= shift_d;
            bit_q      <= bit_d;
            ptr_q      <= ptr_d;
            have_ptr_q <= have_ptr_d;
            drive_q    <= drive_d;
            out_q      <= out_d;
            busy_q     <= busy_d;
            nack_q     <= nack_d;
            wr_q       <= wr_d;
            rd_q       <= rd_d;
            pop_q      <= pop_d;
            wdata_q    <= wdata_d;
            waddr_q    <= waddr_d;
            to_fifo_q  <= to_fifo_d;
            scl_q      <= scl_f;
            sda_q      <= sda_f;
        end
    end

    // Write data bound for the FIFO location passes through a small buffer.
    i2c_byte_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
        .i_clock     (i_clock),
        .i_rst       (i_rst),
        .i_in_valid  (to_fifo_q),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (wdata_q),
        .o_out_valid (o_fifo_valid),
        .i_out_ready (i_fifo_ready),
        .o_out_data  (o_fifo_data)
    );

    // The clock line has no output at all; data is released while the clock is high
    // on the short link, whatever value out_q holds.
    assign o_sda      = out_q;
    assign o_sda_oe_n = !(drive_q && (!i_push_pull_short_link || !scl_f));
    assign o_reg_wr    = wr_q;
    assign o_reg_rd    = rd_q;
    assign o_reg_addr  = waddr_q;
    assign o_reg_wdata = wdata_q;
    assign o_rfifo_pop = pop_q && i_rfifo_valid;
    assign o_busy      = busy_q;

    a_ack_release: assert property (@(posedge i_clock) disable iff (i_rst)
        (state_q == ST_TACK) |-> o_sda_oe_n)
        else $error("Data line driven during master acknowledge.");
    a_stop_idles: assert property (@(posedge i_clock) disable iff (i_rst)
        (stop_seen && i_port_select) |=> (state_q == ST_IDLE && !o_busy))
        else $error("Stop did not free the bus.");
    a_start_addr: assert property (@(posedge i_clock) disable iff (i_rst)
        (start_seen && i_port_select && !stop_seen) |=> state_q == ST_ADDR)
        else $error("Start did not enter address phase.");
    a_fifo_ptr_hold: assert property (@(posedge i_clock) disable iff (i_rst)
        (rd_q && waddr_q == FIFO_REG_ADDR) |-> ptr_q == FIFO_REG_ADDR)
        else $error("Pointer moved while reading the FIFO location.");
    a_rd_ptr_inc: assert property (@(posedge i_clock) disable iff (i_rst)
        (rd_q && waddr_q != FIFO_REG_ADDR) |-> ptr_q == waddr_q + 8'h01)
        else $error("Read pointer did not advance by one.");
    a_wr_ptr_inc: assert property (@(posedge i_clock) disable iff (i_rst)
        wr_q |-> (ptr_q == waddr_q + 8'h01 && waddr_q != FIFO_REG_ADDR))
        else $error("Write pointer did not advance by one.");
    a_short_release: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_push_pull_short_link && scl_f) |-> o_sda_oe_n)
        else $error("Short link data driven while clock high.");
    a_idle_release: assert property (@(posedge i_clock) disable iff (i_rst)
        (state_q == ST_IDLE) |=> o_sda_oe_n || state_q != ST_IDLE)
        else $error("Data driven while idle.");
endmodule : i2c_slave_register_port
`default_nettype wire

// File: host_master_model.sv
`default_nettype none
module host_master_model (
    input  wire logic       i_clock,
    input  wire logic       i_sda,
    output logic            o_scl,
    output logic            o_sda,
    output logic            o_rx_valid,
    output logic [7:0]      o_rx_byte
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        o_scl      = 1'b1;
        o_sda      = 1'b1;
        o_rx_valid = 1'b0;
        o_rx_byte  = 8'h00;
    end
    task automatic w(input int n);
        repeat (n) @(posedge i_clock);
    endtask : w
    // Clock low 6 cycles, high 2 cycles; data moves mid-low.
    task automatic clock_bit(input logic b, output logic r);
        w(3);
        o_sda <= b;
        w(3);
        o_scl <= 1'b1;
        w(1);
        @(negedge i_clock);
        r = i_sda;
        @(posedge i_clock);
        o_scl <= 1'b0;
    endtask : clock_bit
    task automatic start_cond();
        w(3);
        o_sda <= 1'b1;
        w(3);
        o_scl <= 1'b1;
        w(4);
        o_sda <= 1'b0;
        w(4);
        o_scl <= 1'b0;
    endtask : start_cond
    task automatic stop_cond();
        w(3);
        o_sda <= 1'b0;
        w(3);
        o_scl <= 1'b1;
        w(4);
        o_sda <= 1'b1;
        w(8);
    endtask : stop_cond
    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) clock_bit(d[i], r);
        clock_bit(1'b1, ack);
    endtask : write_byte
    task automatic read_byte(input logic last, output logic [7:0] d, output logic r);
        for (int i = 7; i >= 0; i--) clock_bit(1'b1, d[i]);
        clock_bit(last, r);
        o_rx_byte  <= d;
        o_rx_valid <= 1'b1;
        w(1);
        o_rx_valid <= 1'b0;
    endtask : read_byte
endmodule : host_master_model
`default_nettype wire

// File: tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import i2c_port_pkg::*;
    logic        clk, rst, src, sda, oe_n, wr, rd, fv, fr, rv, pop, busy, rxv, ack, scl, msda;
    logic        sel, spp;
    logic [1:0]  aset, apin, lows;
    logic [7:0]  waddr, wdat, rdat, fd, rfd, rxb, d, ptr, rptr;
    logic [7:0]  fifo_m [$];
    logic [7:0]  regs [256];
    logic [7:0]  keep [8];
    logic [15:0] wr_q [$];
    logic [7:0]  rd_q [$];
    logic [31:0] seed;
    int          mismatches, tests_run;
    wire logic   line = msda & (oe_n | sda);
    assign rdat = regs[rptr];
    host_master_model i_master (.i_clock(clk), .i_sda(line), .o_scl(scl), .o_sda(msda),
        .o_rx_valid(rxv), .o_rx_byte(rxb));
    i2c_slave_register_port i_dut (.i_clock(clk), .i_rst(rst), .i_port_select(sel),
        .i_push_pull_short_link(spp), .i_addr_from_setting(src), .i_addr_setting(aset),
        .i_addr_pins(apin), .i_scl(scl), .i_sda(line), .o_sda(sda), .o_sda_oe_n(oe_n),
        .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_addr(waddr), .o_reg_wdata(wdat),
        .i_reg_rdata(rdat), .o_fifo_valid(fv), .i_fifo_ready(fr), .o_fifo_data(fd),
        .i_rfifo_valid(rv), .o_rfifo_pop(pop), .i_rfifo_data(rfd), .o_busy(busy));
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : rnd
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic give_verdict();
        $display("Mismatches %0d, comparisons %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : give_verdict
    // Result watcher: register writes and bytes read by the master.
    always @(posedge clk)
    begin
        if (wr === 1'b1)
        begin
            regs[waddr] <= wdat;
            check({waddr, wdat}, (wr_q.size() > 0) ? wr_q.pop_front() : 16'hxxxx);
        end
        if (rxv === 1'b1)
            check(rxb, (rd_q.size() > 0) ? rd_q.pop_front() : 8'hxx);
        if (rd === 1'b1)
        begin
            check(waddr, rptr);
            rptr <= (rptr == FIFO_REG_ADDR) ? rptr : rptr + 8'h01;
        end
        if (fv === 1'b1 && fr === 1'b1)
            fifo_m.push_back(fd);
        if (pop === 1'b1)
            void'(fifo_m.pop_front());
        fr  <= fifo_m.size() < FIFO_DEPTH;
        rv  <= fifo_m.size() > 0;
        rfd <= (fifo_m.size() > 0) ? fifo_m[0] : 8'h00;
    end
    task automatic frame(input logic [7:0] first, input logic exp_ack);
        i_master.start_cond();
        i_master.write_byte(first, ack);
        check(ack, exp_ack);
    endtask : frame
    task automatic set_ptr(input logic [7:0] p);
        rptr = p;
        frame({ADDR_FIXED_BITS, lows, DIR_WRITE}, 1'b0);
        i_master.write_byte(p, ack);
        check(ack, 1'b0);
    endtask : set_ptr
    task automatic read_n(input int n);
        frame({ADDR_FIXED_BITS, lows, DIR_READ}, 1'b0);
        for (int k = 0; k < n; k++)
        begin
            rd_q.push_back(keep[k]);
            i_master.read_byte(k == n - 1, d, ack);
        end
        check(ack, 1'b1);
        i_master.stop_cond();
    endtask : read_n
    initial
    begin
        repeat (40000) @(posedge clk);
        mismatches++;
        give_verdict();
    end
    initial
    begin
        seed = 32'hbfb0_ec30;
        mismatches = 0;
        tests_run = 0;
        rst = 1'b1;
        sel = 1'b1;
        spp = 1'b0;
        rptr = 8'h00;
        src = 1'b0;
        aset = 2'h0;
        apin = 2'h0;
        lows = 2'h0;
        for (int i = 0; i < 256; i++) regs[i] = 8'h00;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        check({busy, oe_n}, 2'h1);
        for (int s = 0; s < 3; s++)
        begin
            lows = 2'(rnd());
            if (s == 2)
                lows[1] = 1'b0;
            src  <= (s == 1);
            spp  <= (s == 2);
            aset <= (s == 1) ? lows : ~lows;
            apin <= (s == 1) ? ~lows : ((s == 2) ? {1'b1, lows[0]} : lows);
            frame({ADDR_FIXED_BITS, ~lows, DIR_WRITE}, 1'b1);
            i_master.stop_cond();
            ptr = 8'h10 + 8'(s * 8);
            set_ptr(ptr);
            for (int k = 0; k < 3; k++)
            begin
                keep[k] = rnd();
                wr_q.push_back({ptr + 8'(k), keep[k]});
                i_master.write_byte(keep[k], ack);
                check(ack, 1'b0);
            end
            check(busy, 1'b1);
            i_master.stop_cond();
            check(busy, 1'b0);
            set_ptr(ptr);
            read_n(3);
            check(oe_n, 1'b1);
        end
        frame(8'h00, 1'b1);
        i_master.stop_cond();
        set_ptr(FIFO_REG_ADDR);
        for (int k = 0; k < FIFO_DEPTH; k++)
        begin
            keep[k] = rnd();
            i_master.write_byte(keep[k], ack);
        end
        i_master.stop_cond();
        check(fr, 1'b0);
        set_ptr(FIFO_REG_ADDR);
        read_n(FIFO_DEPTH);
        check(rv, 1'b0);
        sel <= 1'b0;
        frame({ADDR_FIXED_BITS, lows, DIR_WRITE}, 1'b1);
        i_master.stop_cond();
        sel <= 1'b1;
        check(busy, 1'b0);
        check(16'(wr_q.size() + rd_q.size()), 16'h0000);
        give_verdict();
    end
endmodule : tb
`default_nettype wire
